// [verilog/atch_core.sv]
// Task-file command handler with AHB-Lite register slave
`timescale 1ns/1ns
`include "atch_consts.svh"

module atch_core #(
  parameter int IDLE_CYC    = `ATCH_IDLE_CYC,
  parameter int MAX_BLOCK   = 16,
  parameter int MAX_PIO     = 6,
  parameter int MAX_MDMA    = 4,
  parameter bit HAS_DMA     = 1'b1,
  parameter bit HAS_SEC     = 1'b0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             intrq,
  output logic             iois16_en,
  output logic             sleeping,
  output logic             freeze_lock
);

  initial begin
    if (MAX_BLOCK < 1 || MAX_BLOCK > 128) $error("MAX_BLOCK out of range");
    if (MAX_PIO > 7 || MAX_MDMA > 7) $error("mode limit out of range");
    if (IDLE_CYC < 1) $error("IDLE_CYC must be positive");
  end

  // ********************************************************************
  // Bus slave
  // ********************************************************************
  logic        wr_ph_q;
  logic        rd_ph_q;
  logic [7:0]  addr_q;
  logic        take;
  logic        wr_en;

  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = wr_ph_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      addr_q  <= 8'h00;
    end else begin
      wr_ph_q <= take & hwrite;
      rd_ph_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // ********************************************************************
  // Task file
  // ********************************************************************
  atch_pkg::atch_state_e state_q;
  atch_pkg::atch_feat_s  feat_q;
  logic [7:0]  feature_q;
  logic [7:0]  seccnt_q;
  logic [7:0]  secnum_q;
  logic [7:0]  cyllo_q;
  logic [7:0]  cylhi_q;
  logic [7:0]  drvhead_q;
  logic [7:0]  cmd_q;
  logic [7:0]  error_q;
  logic        err_q;
  logic        drq_q;
  logic        cmd_wr;
  logic        srst;
  logic [27:0] max_lba_q;
  logic [15:0] max_cyl_q;
  logic [3:0]  max_head_q;
  logic [5:0]  max_sec_q;
  logic        erased_q;
  logic [23:0] hot_q;
  logic [7:0]  block_q;
  logic        mult_en_q;
  logic [8:0]  bptr_q;
  logic [7:0]  buf_mem [0:511];

  assign cmd_wr = wr_en && addr_q == `ATCH_OFF_CMD && state_q == atch_pkg::ST_IDLE;
  assign srst   = wr_en && addr_q == `ATCH_OFF_SRST && hwdata[2];

  function automatic logic addr_bad(input logic [7:0] dh, input logic [7:0] ch, input logic [7:0] cl,
                                    input logic [7:0] sn, input logic [27:0] mlba, input logic [15:0] mc,
                                    input logic [3:0] mh, input logic [5:0] ms);
    if (dh[`ATCH_DH_LBA]) begin
      addr_bad = {dh[3:0], ch, cl, sn} > mlba;
    end else begin
      addr_bad = {ch, cl} > mc || dh[3:0] > mh || sn == 8'h00 || sn > {2'b00, ms};
    end
  endfunction

  // Decoded feature check; unknown codes and bad 03h parameters abort
  function automatic logic feat_ok(input logic [7:0] f, input logic [7:0] sc);
    case (f)
      `ATCH_FT_8BIT_ON, `ATCH_FT_8BIT_OFF, `ATCH_FT_WC_ON, `ATCH_FT_WC_OFF,
      `ATCH_FT_APM_ON, `ATCH_FT_APM_OFF, `ATCH_FT_EXTP_ON, `ATCH_FT_EXTP_OFF,
      `ATCH_FT_PL1_ON, `ATCH_FT_PL1_OFF, `ATCH_FT_ECC_VS, `ATCH_FT_ECC_4,
      `ATCH_FT_RLA_OFF, `ATCH_FT_RLA_ON, `ATCH_FT_POR_OFF, `ATCH_FT_POR_ON,
      `ATCH_FT_NOP_A, `ATCH_FT_NOP_B, `ATCH_FT_COMPAT: feat_ok = 1'b1;
      `ATCH_FT_XFER: begin
        case (sc[7:3])
          `ATCH_XT_PIO_DEF: feat_ok = sc[2:1] == 2'b00;
          `ATCH_XT_PIO_FC:  feat_ok = 32'(sc[2:0]) <= MAX_PIO;
          `ATCH_XT_MDMA:    feat_ok = HAS_DMA && 32'(sc[2:0]) <= MAX_MDMA;
          default:          feat_ok = 1'b0;
        endcase
      end
      default: feat_ok = 1'b0;
    endcase
  endfunction

  function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
    is_cmd = c == a || c == b;
  endfunction

  // ********************************************************************
  // Register writes from the host
  // ********************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feature_q  <= 8'h00;
      secnum_q   <= 8'h01;
      cyllo_q    <= 8'h00;
      cylhi_q    <= 8'h00;
      drvhead_q  <= 8'ha0;
      cmd_q      <= 8'h00;
      max_lba_q  <= 28'h0000000;
      max_cyl_q  <= 16'h0000;
      max_head_q <= 4'h0;
      max_sec_q  <= 6'h00;
      erased_q   <= 1'b0;
      hot_q      <= 24'h000000;
    end else if (wr_en && state_q == atch_pkg::ST_IDLE) begin
      case (addr_q)
        `ATCH_OFF_FEATURE: feature_q <= hwdata[7:0];
        `ATCH_OFF_SECNUM:  secnum_q  <= hwdata[7:0];
        `ATCH_OFF_CYLLO:   cyllo_q   <= hwdata[7:0];
        `ATCH_OFF_CYLHI:   cylhi_q   <= hwdata[7:0];
        `ATCH_OFF_DRVHEAD: drvhead_q <= hwdata[7:0];
        `ATCH_OFF_CMD:     cmd_q     <= hwdata[7:0];
        `ATCH_OFF_CONFIG: begin
          max_cyl_q  <= hwdata[15:0];
          max_head_q <= hwdata[19:16];
          max_sec_q  <= hwdata[25:20];
        end
        `ATCH_OFF_MEDIA:   max_lba_q <= hwdata[27:0];
        `ATCH_OFF_XLAT: begin
          hot_q    <= hwdata[23:0];
          erased_q <= hwdata[31];
        end
        default: ;
      endcase
    end
  end

  // ********************************************************************
  // Command sequencer
  // ********************************************************************
  logic [3:0] flush_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= atch_pkg::ST_IDLE;
      flush_q <= 4'h0;
      bptr_q  <= 9'h000;
    end else begin
      case (state_q)
        atch_pkg::ST_IDLE: begin
          if (cmd_wr) begin
            state_q <= atch_pkg::ST_EXEC;
          end else if (wr_en && addr_q == `ATCH_OFF_BUFPTR) begin
            bptr_q <= hwdata[8:0];
          end else if ((wr_en || rd_ph_q) && addr_q == `ATCH_OFF_BUFDATA && drq_q) begin
            bptr_q <= bptr_q + 9'h001;
          end
        end
        atch_pkg::ST_EXEC: begin
          if (cmd_q == `ATCH_CMD_SETFEAT && feature_q == `ATCH_FT_WC_OFF && feat_q.wcache) begin
            flush_q <= 4'(`ATCH_FLUSH_CYC);
            state_q <= atch_pkg::ST_FLUSH;
          end else if (cmd_q == `ATCH_CMD_XLAT &&
                       !addr_bad(drvhead_q, cylhi_q, cyllo_q, secnum_q, max_lba_q, max_cyl_q,
                                 max_head_q, max_sec_q)) begin
            bptr_q  <= 9'h000;
            state_q <= atch_pkg::ST_FILL;
          end else begin
            state_q <= atch_pkg::ST_DONE;
          end
        end
        atch_pkg::ST_FLUSH: begin
          flush_q <= flush_q - 4'h1;
          if (flush_q == 4'h1) begin
            state_q <= atch_pkg::ST_DONE;
          end
        end
        atch_pkg::ST_FILL: begin
          bptr_q <= bptr_q + 9'h001;
          if (bptr_q == 9'h1ff) begin
            state_q <= atch_pkg::ST_DONE;
          end
        end
        atch_pkg::ST_DONE: state_q <= atch_pkg::ST_IDLE;
        default:           state_q <= atch_pkg::ST_IDLE;
      endcase
    end
  end

  // Translate buffer; cylinder and the hot_q count are stored most significant byte first
  logic [7:0] fill_byte;
  always_comb begin
    fill_byte = 8'h00;
    case (bptr_q)
      9'h000: fill_byte = cylhi_q;
      9'h001: fill_byte = cyllo_q;
      9'h002: fill_byte = {4'h0, drvhead_q[3:0]};
      9'h003: fill_byte = secnum_q;
      9'h004: fill_byte = cylhi_q;
      9'h005: fill_byte = cyllo_q;
      9'h006: fill_byte = secnum_q;
      `ATCH_XB_ERASED: fill_byte = erased_q ? 8'hff : 8'h00;
      `ATCH_XB_HOT0:   fill_byte = hot_q[23:16];
      `ATCH_XB_HOT1:   fill_byte = hot_q[15:8];
      `ATCH_XB_HOT2:   fill_byte = hot_q[7:0];
      default:         fill_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk) begin
    if (state_q == atch_pkg::ST_FILL) begin
      buf_mem[bptr_q] <= fill_byte;
    end else if (wr_en && addr_q == `ATCH_OFF_BUFDATA && state_q == atch_pkg::ST_IDLE) begin
      buf_mem[bptr_q] <= hwdata[7:0];
    end
  end

  // ********************************************************************
  // Completion: status, error, features, multiple mode
  // ********************************************************************
  logic done;
  logic fail;
  logic [7:0] fail_code;
  assign done = state_q == atch_pkg::ST_DONE;

  always_comb begin
    fail      = 1'b0;
    fail_code = `ATCH_ERR_ABRT;
    if (cmd_q[7:4] == `ATCH_CMD_SEEK_HI || cmd_q == `ATCH_CMD_XLAT) begin
      fail      = addr_bad(drvhead_q, cylhi_q, cyllo_q, secnum_q, max_lba_q, max_cyl_q,
                           max_head_q, max_sec_q);
      fail_code = `ATCH_ERR_IDNF;
    end else if (cmd_q == `ATCH_CMD_SETFEAT) begin
      fail = !feat_ok(feature_q, seccnt_q);
    end else if (cmd_q == `ATCH_CMD_SETMULT) begin
      fail = seccnt_q != 8'h00 && 32'(seccnt_q) > MAX_BLOCK;
    end else if (is_cmd(cmd_q, `ATCH_CMD_RDMULT, `ATCH_CMD_WRMULT) || cmd_q == `ATCH_CMD_WRMULT_NE) begin
      fail = !mult_en_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_q   <= 1'b0;
      error_q <= 8'h00;
      drq_q   <= 1'b0;
      intrq   <= 1'b0;
    end else begin
      if (done) begin
        err_q   <= fail;
        error_q <= fail ? fail_code : 8'h00;
        drq_q   <= cmd_q == `ATCH_CMD_XLAT && !fail;
      end else if (cmd_wr) begin
        err_q <= 1'b0;
        drq_q <= 1'b0;
      end else if (drq_q && bptr_q == 9'h1ff && (wr_en || rd_ph_q) && addr_q == `ATCH_OFF_BUFDATA) begin
        drq_q <= 1'b0;
      end
      // Completion wins over a status read clearing the request
      if (done) begin
        intrq <= 1'b1;
      end else if ((rd_ph_q && addr_q == `ATCH_OFF_STATUS) || cmd_wr) begin
        intrq <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feat_q    <= '{rla: 1'b1, default: '0};
      block_q   <= 8'h00;
      mult_en_q <= 1'b0;
      seccnt_q  <= 8'h01;
    end else if (srst && !feat_q.keep_cfg) begin
      feat_q    <= '{rla: 1'b1, default: '0};
      block_q   <= 8'h00;
      mult_en_q <= 1'b0;
    end else if (wr_en && addr_q == `ATCH_OFF_SECCNT && state_q == atch_pkg::ST_IDLE) begin
      seccnt_q <= hwdata[7:0];
    end else if (done && fail && cmd_q == `ATCH_CMD_SETMULT) begin
      mult_en_q <= 1'b0;
    end else if (done && !fail) begin
      if (cmd_q == `ATCH_CMD_SETMULT) begin
        block_q   <= seccnt_q;
        mult_en_q <= seccnt_q != 8'h00;
      end else if (cmd_q == `ATCH_CMD_WEAR && !HAS_SEC) begin
        seccnt_q <= 8'h00;
      end else if (cmd_q == `ATCH_CMD_SETFEAT) begin
        case (feature_q)
          `ATCH_FT_8BIT_ON:  feat_q.byte_mode <= 1'b1;
          `ATCH_FT_8BIT_OFF: feat_q.byte_mode <= 1'b0;
          `ATCH_FT_WC_ON:    feat_q.wcache    <= 1'b1;
          `ATCH_FT_WC_OFF:   feat_q.wcache    <= 1'b0;
          `ATCH_FT_APM_ON:   feat_q.apm       <= 1'b1;
          `ATCH_FT_APM_OFF:  feat_q.apm       <= 1'b0;
          `ATCH_FT_EXTP_ON:  feat_q.ext_power <= 1'b1;
          `ATCH_FT_EXTP_OFF: feat_q.ext_power <= 1'b0;
          `ATCH_FT_PL1_ON:   feat_q.pl1       <= 1'b1;
          `ATCH_FT_PL1_OFF:  feat_q.pl1       <= 1'b0;
          `ATCH_FT_ECC_VS:   feat_q.ecc_vs    <= 1'b1;
          `ATCH_FT_ECC_4:    feat_q.ecc_vs    <= 1'b0;
          `ATCH_FT_RLA_OFF:  feat_q.rla       <= 1'b0;
          `ATCH_FT_RLA_ON:   feat_q.rla       <= 1'b1;
          `ATCH_FT_POR_OFF:  feat_q.keep_cfg  <= 1'b1;
          `ATCH_FT_POR_ON:   feat_q.keep_cfg  <= 1'b0;
          `ATCH_FT_XFER: begin
            // One register per mode family; setting one family leaves the other family's mode unchanged
            if (seccnt_q[7:3] == `ATCH_XT_MDMA) begin
              feat_q.mdma_mode <= seccnt_q[2:0];
            end else begin
              feat_q.pio_fc    <= seccnt_q[7:3] == `ATCH_XT_PIO_FC;
              feat_q.pio_mode  <= seccnt_q[7:3] == `ATCH_XT_PIO_FC ? seccnt_q[2:0] : 3'h0;
              feat_q.iordy_off <= seccnt_q[7:3] == `ATCH_XT_PIO_DEF && seccnt_q[0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ********************************************************************
  // Power: sleep by command or idle timer, wake on any command
  // ********************************************************************
  logic [$clog2(IDLE_CYC+1)-1:0] idle_q;
  logic sleep_cmd;
  assign sleep_cmd = is_cmd(cmd_q, `ATCH_CMD_SLEEP_A, `ATCH_CMD_SLEEP_B) ||
                     is_cmd(cmd_q, `ATCH_CMD_STBY_A, `ATCH_CMD_STBY_B) ||
                     is_cmd(cmd_q, `ATCH_CMD_STBYI_A, `ATCH_CMD_STBYI_B);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleeping    <= 1'b0;
      idle_q      <= '0;
      freeze_lock <= 1'b0;
    end else begin
      if (done && cmd_q == `ATCH_CMD_WEAR && HAS_SEC) begin
        freeze_lock <= 1'b1;
      end
      if (cmd_wr || take) begin
        idle_q <= '0;
      end else if (!sleeping && state_q == atch_pkg::ST_IDLE) begin
        idle_q <= idle_q + 1'b1;
      end
      if (cmd_wr) begin
        sleeping <= 1'b0;
      end else if (done && sleep_cmd) begin
        sleeping <= 1'b1;
      end else if (32'(idle_q) >= IDLE_CYC - 1 && state_q == atch_pkg::ST_IDLE) begin
        sleeping <= 1'b1;
      end
    end
  end

  // Byte-wide mode drops the 16-bit indication
  assign iois16_en = !feat_q.byte_mode;

  // ********************************************************************
  // Read data
  // ********************************************************************
  logic [7:0] status;
  assign status = {state_q != atch_pkg::ST_IDLE, 1'b1, 2'b00, drq_q, 2'b00, err_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      case (haddr[7:0])
        `ATCH_OFF_ERROR:   hrdata <= {24'h000000, error_q};
        `ATCH_OFF_SECCNT:  hrdata <= {24'h000000, seccnt_q};
        `ATCH_OFF_SECNUM:  hrdata <= {24'h000000, secnum_q};
        `ATCH_OFF_CYLLO:   hrdata <= {24'h000000, cyllo_q};
        `ATCH_OFF_CYLHI:   hrdata <= {24'h000000, cylhi_q};
        `ATCH_OFF_DRVHEAD: hrdata <= {24'h000000, drvhead_q};
        `ATCH_OFF_STATUS:  hrdata <= {24'h000000, status};
        `ATCH_OFF_CONFIG:  hrdata <= {6'h00, max_sec_q, max_head_q, max_cyl_q};
        `ATCH_OFF_MEDIA:   hrdata <= {4'h0, max_lba_q};
        `ATCH_OFF_XLAT:    hrdata <= {erased_q, 7'h00, hot_q};
        `ATCH_OFF_BUFPTR:  hrdata <= {11'h000, mult_en_q, block_q, sleeping, feat_q.byte_mode,
                                      feat_q.wcache, bptr_q};
        `ATCH_OFF_BUFDATA: hrdata <= {24'h000000, buf_mem[bptr_q]};
        default:           hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// [verilog/atch_consts.svh]
// Register offsets, field positions, codes and timing counts of the task-file command handler
`ifndef ATCH_CONSTS_SVH
`define ATCH_CONSTS_SVH

// Task-file registers are word spaced: byte address is four times the index
`define ATCH_IDX_ERROR      1
`define ATCH_IDX_FEATURE    1
`define ATCH_IDX_SECCNT     2
`define ATCH_IDX_SECNUM     3
`define ATCH_IDX_CYLLO      4
`define ATCH_IDX_CYLHI      5
`define ATCH_IDX_DRVHEAD    6
`define ATCH_IDX_CMD        7
`define ATCH_IDX_STATUS     7

`define ATCH_OFF_ERROR      8'(`ATCH_IDX_ERROR * 4)
`define ATCH_OFF_FEATURE    8'(`ATCH_IDX_FEATURE * 4)
`define ATCH_OFF_SECCNT     8'(`ATCH_IDX_SECCNT * 4)
`define ATCH_OFF_SECNUM     8'(`ATCH_IDX_SECNUM * 4)
`define ATCH_OFF_CYLLO      8'(`ATCH_IDX_CYLLO * 4)
`define ATCH_OFF_CYLHI      8'(`ATCH_IDX_CYLHI * 4)
`define ATCH_OFF_DRVHEAD    8'(`ATCH_IDX_DRVHEAD * 4)
`define ATCH_OFF_CMD        8'(`ATCH_IDX_CMD * 4)
`define ATCH_OFF_STATUS     8'(`ATCH_IDX_STATUS * 4)
`define ATCH_OFF_CONFIG     8'h20
`define ATCH_OFF_MEDIA      8'h24
`define ATCH_OFF_XLAT       8'h28
`define ATCH_OFF_BUFPTR     8'h2c
`define ATCH_OFF_BUFDATA    8'h30
`define ATCH_OFF_SRST       8'h34

`define ATCH_ST_BSY         7
`define ATCH_ST_DRDY        6
`define ATCH_ST_DRQ         3
`define ATCH_ST_ERR         0
`define ATCH_ERR_ABRT       8'h04
`define ATCH_ERR_IDNF       8'h10
`define ATCH_DH_LBA         6

`define ATCH_CMD_SEEK_HI    4'h7
`define ATCH_CMD_SETFEAT    8'hef
`define ATCH_CMD_SETMULT    8'hc6
`define ATCH_CMD_SLEEP_A    8'h99
`define ATCH_CMD_SLEEP_B    8'he6
`define ATCH_CMD_STBY_A     8'h96
`define ATCH_CMD_STBY_B     8'he2
`define ATCH_CMD_STBYI_A    8'h94
`define ATCH_CMD_STBYI_B    8'he0
`define ATCH_CMD_XLAT       8'h87
`define ATCH_CMD_WEAR       8'hf5
`define ATCH_CMD_RDMULT     8'hc4
`define ATCH_CMD_WRMULT     8'hc5
`define ATCH_CMD_WRMULT_NE  8'hcd

`define ATCH_FT_8BIT_ON     8'h01
`define ATCH_FT_8BIT_OFF    8'h81
`define ATCH_FT_WC_ON       8'h02
`define ATCH_FT_WC_OFF      8'h82
`define ATCH_FT_XFER        8'h03
`define ATCH_FT_APM_ON      8'h05
`define ATCH_FT_APM_OFF     8'h85
`define ATCH_FT_EXTP_ON     8'h09
`define ATCH_FT_EXTP_OFF    8'h89
`define ATCH_FT_PL1_ON      8'h0a
`define ATCH_FT_PL1_OFF     8'h8a
`define ATCH_FT_ECC_VS      8'h44
`define ATCH_FT_ECC_4       8'hbb
`define ATCH_FT_RLA_OFF     8'h55
`define ATCH_FT_RLA_ON      8'haa
`define ATCH_FT_POR_OFF     8'h66
`define ATCH_FT_POR_ON      8'hcc
`define ATCH_FT_NOP_A       8'h69
`define ATCH_FT_NOP_B       8'h96
`define ATCH_FT_COMPAT      8'h97

`define ATCH_XT_PIO_DEF     5'h00
`define ATCH_XT_PIO_FC      5'h01
`define ATCH_XT_MDMA        5'h04

`define ATCH_IDLE_US        5000
`define ATCH_CLK_MHZ        25
`define ATCH_IDLE_CYC       (`ATCH_IDLE_US * `ATCH_CLK_MHZ)
`define ATCH_FLUSH_CYC      8

`define ATCH_XB_ERASED      9'h013
`define ATCH_XB_HOT0        9'h018
`define ATCH_XB_HOT1        9'h019
`define ATCH_XB_HOT2        9'h01a

`endif

// [verilog/atch_pkg.sv]
// Types shared by the task-file command handler
package atch_pkg;
  typedef struct packed {
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
  } atch_ahb_req_s;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_EXEC  = 5'b00010,
    ST_FLUSH = 5'b00100,
    ST_FILL  = 5'b01000,
    ST_DONE  = 5'b10000
  } atch_state_e;

  typedef struct packed {
    logic       byte_mode;
    logic       wcache;
    logic       apm;
    logic       ext_power;
    logic       pl1;
    logic       ecc_vs;
    logic       rla;
    logic       keep_cfg;
    logic [2:0] pio_mode;
    logic       pio_fc;
    logic       iordy_off;
    logic [2:0] mdma_mode;
  } atch_feat_s;
endpackage

// [tb/atch_core_monitor.sv]
// Port checker for the task-file command handler
`timescale 1ns/1ns
module atch_core_monitor #(parameter int IDLE_CYC = 50) (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic        hwrite,
  input logic        hreadyout,
  input logic        hresp,
  input logic        intrq,
  input logic        sleeping,
  input logic        freeze_lock,
  input logic [1:0]  htrans,
  input logic [31:0] haddr,
  input logic [31:0] hwdata,
  input logic [31:0] hrdata
);
  logic go, slp, cmd_q, rd_q;
  int   idle_q;
  assign go = hsel && htrans[1];
  assign slp = hwdata[7:0] inside {8'h99, 8'he6, 8'h96, 8'he2, 8'h94, 8'he0};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      cmd_q <= go && hwrite && haddr == 32'h1c;
      rd_q <= go && !hwrite;
    end
  end
  // Any bus traffic restarts the idle span, as it does inside the card
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) idle_q <= 0;
    else idle_q <= go ? 0 : idle_q + 1;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_no_freeze: assert property (!freeze_lock) else $error("freeze lock raised");
  a_rdata_hold: assert property (!rd_q |-> $stable(hrdata)) else $error("read data moved");
  a_idle_sleep: assert property (idle_q > IDLE_CYC + 8 |-> sleeping) else $error("idle sleep missed");
  a_sleep_entry: assert property (cmd_q && slp |-> ##[2:4] sleeping) else $error("no sleep");
  a_cmd_wakes: assert property (sleeping && go && hwrite && haddr == 32'h1c ##1 !slp |-> ##[0:4] !sleeping)
    else $error("no wake");
  a_status_clears: assert property (go && !hwrite && haddr == 32'h1c && intrq |-> ##[1:2] !intrq)
    else $error("interrupt kept");
endmodule

// [tb/atch_host.sv]
// Host-side bus master that drives the task file
`timescale 1ns/1ns
module atch_host (
  input  logic        hclk,
  input  logic        hready,
  input  logic [31:0] hrdata,
  output logic        hsel = 1'b1,
  output logic [31:0] haddr = 32'h0,
  output logic [1:0]  htrans = 2'h0,
  output logic        hwrite = 1'b0,
  output logic [2:0]  hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0
);
  // One address phase then one data phase, each waiting for hready; hsize stays at word size
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // Released data turns over so a stale value never looks valid
    hwdata <= ~d;
  endtask
endmodule

// [tb/test_ata_card_command_handler.sv]
// Self-checking bench for the task-file command handler
`timescale 1ns/1ns
module test_ata_card_command_handler;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hready, hreadyout, hresp, intrq, iois16_en, sleeping, freeze_lock;
  logic [1:0]  htrans, ev;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q, st;
  logic [7:0]  b [27];
  logic [7:0]  ft [18] = '{8'h01, 8'h81, 8'h02, 8'h82, 8'h05, 8'h85, 8'h09, 8'h89, 8'h0a, 8'h8a, 8'h44,
                           8'hbb, 8'h55, 8'haa, 8'hcc, 8'h69, 8'h96, 8'h97};
  logic [15:0] xm [10] = '{16'h0000, 16'h0100, 16'h0c00, 16'h2200, 16'h2400, 16'h2504, 16'h0f04,
                           16'h1004, 16'h4004, 16'h8004};
  logic [7:0]  sl [6] = '{8'h99, 8'he6, 8'h96, 8'he2, 8'h94, 8'he0};
  logic [7:0]  mc [3] = '{8'hc4, 8'hc5, 8'hcd};
  int          n_mismatch = 0;
  int          checks = 0;
  assign hready = hreadyout;
  always #20 hclk = ~hclk;
  atch_core #(.IDLE_CYC(50)) DUT (.*);
  atch_host host (.*);
  task automatic chk(input logic [31:0] g, m, e);
    checks++;
    if ((g & m) !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g & m, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic idle();
    st = 32'h80;
    for (int i = 0; i < 300 && st[7] !== 1'b0; i++) begin
      rd(32'h1c);
      st = q;
    end
  endtask
  task automatic cmd(input logic [7:0] c, f, s);
    wr(32'h04, {24'h0, f});
    wr(32'h08, {24'h0, s});
    wr(32'h1c, {24'h0, c});
    repeat (4) @(posedge hclk);
    ev = {sleeping, intrq};
    idle();
  endtask
  task automatic stat(input logic [7:0] e);
    rd(32'h04);
    chk({16'h0, st[7:0], q[7:0]}, 32'h81ff, {23'h0, e != 8'h0, e});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h2c);
    chk(q, 32'h100c00, 32'h0);
    rd(32'h80);
    chk(q, 32'hffffffff, 32'h0);
    cmd(8'hc6, 8'h0, 8'h04);
    rd(32'h2c);
    chk(q, 32'h1ff000, 32'h104000);
    cmd(8'hc6, 8'h0, 8'h11);
    stat(8'h04);
    chk({30'h0, ev}, 32'h1, 32'h1);
    rd(32'h2c);
    chk(q, 32'h100000, 32'h0);
    cmd(8'hc6, 8'h0, 8'h00);
    stat(8'h00);
    rd(32'h2c);
    chk(q, 32'h100000, 32'h0);
    foreach (mc[i]) begin
      cmd(mc[i], 8'h0, 8'h01);
      stat(8'h04);
    end
    foreach (ft[i]) begin
      cmd(8'hef, ft[i], 8'h0);
      stat(8'h00);
    end
    cmd(8'hef, 8'h00, 8'h0);
    stat(8'h04);
    cmd(8'hef, 8'h01, 8'h0);
    chk({31'h0, iois16_en}, 32'h1, 32'h0);
    cmd(8'hef, 8'h81, 8'h0);
    chk({31'h0, iois16_en}, 32'h1, 32'h1);
    for (int k = 0; k < 2; k++) begin
      cmd(8'hef, k ? 8'h82 : 8'h02, 8'h0);
      rd(32'h2c);
      chk(q, 32'h200, k ? 32'h0 : 32'h200);
      cmd(8'hc6, 8'h0, 8'h04);
      cmd(8'hef, k ? 8'hcc : 8'h66, 8'h0);
      wr(32'h34, 32'h4);
      wr(32'h34, 32'h0);
      idle();
      rd(32'h2c);
      chk(q, 32'h100000, k ? 32'h0 : 32'h100000);
    end
    foreach (xm[i]) begin
      cmd(8'hef, 8'h03, xm[i][15:8]);
      stat(xm[i][7:0]);
    end
    wr(32'h24, 32'h3e8);
    wr(32'h18, 32'h40);
    wr(32'h14, 32'h0);
    wr(32'h10, 32'h3);
    for (int j = 0; j < 2; j++) begin
      wr(32'h0c, 32'he8 + j);
      cmd(j ? 8'h7f : 8'h70, 8'h0, 8'h0);
      stat(j ? 8'h10 : 8'h00);
    end
    wr(32'h20, 32'h03ff0064);
    wr(32'h18, 32'ha0);
    wr(32'h10, 32'h64);
    for (int j = 0; j < 2; j++) begin
      wr(32'h0c, j ? 32'h40 : 32'h3f);
      cmd(8'h75, 8'h0, 8'h0);
      stat(j ? 8'h10 : 8'h00);
    end
    wr(32'h24, 32'hfffffff);
    wr(32'h28, 32'h80012345);
    wr(32'h18, 32'h43);
    wr(32'h14, 32'h02);
    wr(32'h10, 32'h01);
    wr(32'h0c, 32'hf4);
    cmd(8'h87, 8'h0, 8'h0);
    wr(32'h2c, 32'h0);
    foreach (b[i]) begin
      rd(32'h30);
      b[i] = q[7:0];
    end
    chk({b[0], b[1], b[2], b[3]}, 32'hffffffff, 32'h020103f4);
    chk({b[4], b[5], b[6], b[19]}, 32'hffffffff, 32'h0201f4ff);
    chk({8'h0, b[24], b[25], b[26]}, 32'hffffff, 32'h012345);
    cmd(8'hf5, 8'h0, 8'h5a);
    rd(32'h08);
    chk(q, 32'hff, 32'h0);
    foreach (sl[i]) begin
      cmd(sl[i], 8'h0, 8'h0);
      chk({30'h0, ev}, 32'h3, 32'h3);
    end
    wr(32'h1c, 32'h70);
    idle();
    chk({31'h0, sleeping}, 32'h1, 32'h0);
    repeat (60) @(posedge hclk);
    chk({31'h0, sleeping}, 32'h1, 32'h1);
    stop_test();
  end
endmodule
bind atch_core atch_core_monitor #(.IDLE_CYC(IDLE_CYC)) mon (.*);
